//--- include/pse_common_pkg.sv
// types shared by the common register decode block
// no assumptions
package pse_common_pkg;
  typedef enum logic [3:0] {
    REG_COMMON_READ = 4'h0,
    REG_COMMON_CTRL = 4'h1,
    REG_PORT_CTRL1 = 4'h2,
    REG_PORT_CTRL2 = 4'h3,
    REG_PORT_STAT1 = 4'h4,
    REG_PORT_STAT2 = 4'h5,
    REG_RES_LO = 4'h6,
    REG_RES_HI = 4'h7,
    REG_VOLT_LO = 4'h8,
    REG_VOLT_HI = 4'h9,
    REG_CURR_LO = 4'hA,
    REG_CURR_HI = 4'hB,
    REG_TEMP_LO = 4'hC,
    REG_TEMP_HI = 4'hD,
    REG_UNUSED = 4'hE,
    REG_TEST_MODE = 4'hF
  } reg_code_e;
  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_ACTIVE = 2'b01
  } sw_reset_state_e;
endpackage

//--- include/pse_common_regs.svh
// field positions, masks and reset values of the common bank
// assumes inclusion by bare name from design files
`ifndef PSE_COMMON_REGS_SVH
`define PSE_COMMON_REGS_SVH
`define SEL_REGCODE_HI 6
`define SEL_REGCODE_LO 3
`define SEL_PORT_HI 1
`define SEL_PORT_LO 0
`define SEL_MASK 8'h7B
`define SEL_RESET 8'h00
`define CTRL_MASK 8'h3F
`define CTRL_RESET 8'h00
`define TEST_MASK 8'h7E
`define TEST_RESET 8'h00
`define CTRL_THERM_DIS 5
`define CTRL_AC_HIGH 4
`define CTRL_AC_LOW 3
`define CTRL_VOLT_DIS 2
`define CTRL_ALL_OFF 1
`define CTRL_SW_RESET 0
`define TEST_FORCE_THERM 6
`define TEST_POR_FORCE 5
`define TEST_DISC_TMR_DIS 4
`define TEST_DISC_HALT 3
`define TEST_DISC_FAST 2
`define TEST_RETRY_DIS 1
`define FAULT_LSB 4
`define SW_RESET_CYCLES 8'h10
`endif

//--- logic/port_fault_flag.sv
// one sticky general fault flag of a port
// assumes set and clear pulses on clk
`timescale 1ns/1ps
module port_fault_flag
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic softReset,
  input wire logic faultSet,
  input wire logic manualMode,
  input wire logic disableCall,
  input wire logic retryExpired,
  output logic flag
);
  logic clearNow;
  assign clearNow = manualMode ? disableCall : retryExpired;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag <= 1'b0;
    else if (softReset)
      flag <= 1'b0;
    else if (faultSet)
      flag <= 1'b1;
    else if (clearNow)
      flag <= 1'b0;
  end
  a_clear_by_mode: assert property (
    @(posedge clk) disable iff (!resetn)
    flag && manualMode && !disableCall && !softReset |=> flag)
    else $error("fault flag dropped without its mode's clear");
  a_auto_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    !manualMode && retryExpired && !faultSet && !softReset |=> !flag)
    else $error("fault flag kept after retry expiry");
  a_set_wins: assert property (
    @(posedge clk) disable iff (!resetn)
    faultSet && !softReset |=> flag)
    else $error("fault event not recorded");
endmodule // port_fault_flag

//--- logic/pse_common_register_decode.sv
// select byte decode and common registers of a four-port power manager
// assumes a serial slave in the clk domain delivers byte strobes
// Notes on behaviour
// - select bits 6..3 give register code: common read, control, port regs
// - codes 6..D pick result bytes; E unused; F is the test register
// - select bits 1..0 pick port one to four
// - select bits 7 and 2 unused as zero; select resets to zero
// - common read bits 7..4 are port 4..1 fault flags, reset zero
// - manual mode: fault flag cleared only by that port's disable call or a software reset
// - automatic mode: fault flag cleared when retry delay timer expires
// - test bit 6 forces thermal shutdown, all ports off
// - test bit 5 forces power-on reset timer out of reset
// - test bit 4 disables both 4 ms discovery timers
// - test bit 3 halts discovery one and two on all ports
// - test bit 2 makes light-load disconnect delay zero
// - test bit 1 disables the 750 ms retry delay timer
// - control bit 5 disables thermal fault; locked after probing
// - control bit 2 disables over and under voltage faults
// - control bit 1 shuts all ports down without ramp
// - control bit 0 resets all circuits and restarts power-on timing
// - common writes act on all ports; port writes on selected port
// - selection latched after eighth select bit, kept for data
`timescale 1ns/1ps
`include "pse_common_regs.svh"
module pse_common_register_decode
#(
  parameter logic [1:0] CHIP_REV = 2'h1, // arbitrary
  parameter logic [1:0] CHIP_ID = 2'h1 // arbitrary
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic selStrobe,
  input wire logic [7:0] selByte,
  input wire logic dataStrobe,
  input wire logic [7:0] wrData,
  input wire logic [3:0] portFaultSet,
  input wire logic [3:0] portDisableCall,
  input wire logic [3:0] retryExpired,
  input wire logic manualModePin,
  input wire logic probeDone,
  output logic [7:0] rdData,
  output logic [3:0] regCode,
  output logic [1:0] portSel,
  output logic [3:0] portWriteStrobe,
  output logic portWriteCommon,
  output logic thermalFaultDisable,
  output logic acHighDrive,
  output logic acLowDrive,
  output logic voltFaultDisable,
  output logic allPortsOff,
  output logic softResetActive,
  output logic forceThermalShutdown,
  output logic porForceRun,
  output logic discoveryTimersOff,
  output logic discoveryHalt,
  output logic disconnectDelayZero,
  output logic retryTimerOff
);
  logic [7:0] sel_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] test_reg;
  logic [7:0] rstCnt_reg;
  logic [3:0] faultFlags;
  logic manualMode;
  logic softReset;
  logic selectReady;
  pse_common_pkg::sw_reset_state_e rst_reg;
  pse_common_pkg::reg_code_e code;

  sel_sync u_mode_sync
  (
    .clk(clk),
    .resetn(resetn),
    .din(manualModePin),
    .dout(manualMode)
  );

  assign code = pse_common_pkg::reg_code_e'(
    sel_reg[`SEL_REGCODE_HI:`SEL_REGCODE_LO]);
  assign regCode = code;
  assign portSel = sel_reg[`SEL_PORT_HI:`SEL_PORT_LO];
  assign softReset = (rst_reg == pse_common_pkg::RST_ACTIVE);
  assign softResetActive = softReset;

  // select byte held until next select strobe or software reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sel_reg <= `SEL_RESET;
    else if (softReset)
      sel_reg <= `SEL_RESET;
    else if (selStrobe)
      sel_reg <= selByte & `SEL_MASK;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      selectReady <= 1'b0;
    else if (softReset)
      selectReady <= 1'b0;
    else if (selStrobe)
      selectReady <= 1'b1;
  end

  // common control register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= `CTRL_RESET;
    else if (softReset)
      ctrl_reg <= `CTRL_RESET;
    else if (dataStrobe && !selStrobe && selectReady &&
             code == pse_common_pkg::REG_COMMON_CTRL)
    begin
      ctrl_reg <= wrData & `CTRL_MASK;
      if (probeDone)
        ctrl_reg[`CTRL_THERM_DIS] <= ctrl_reg[`CTRL_THERM_DIS];
    end
  end

  // test register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      test_reg <= `TEST_RESET;
    else if (softReset)
      test_reg <= `TEST_RESET;
    else if (dataStrobe && !selStrobe && selectReady &&
             code == pse_common_pkg::REG_TEST_MODE)
      test_reg <= wrData & `TEST_MASK;
  end

  // software reset sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_reg <= pse_common_pkg::RST_IDLE;
      rstCnt_reg <= 8'h00;
    end
    else
    begin
      case (rst_reg)
        pse_common_pkg::RST_IDLE:
        begin
          rstCnt_reg <= 8'h00;
          if (ctrl_reg[`CTRL_SW_RESET])
            rst_reg <= pse_common_pkg::RST_ACTIVE;
        end
        pse_common_pkg::RST_ACTIVE:
        begin
          rstCnt_reg <= rstCnt_reg + 8'h01;
          if (rstCnt_reg == `SW_RESET_CYCLES - 8'h01)
            rst_reg <= pse_common_pkg::RST_IDLE;
        end
        default:
          rst_reg <= pse_common_pkg::RST_IDLE;
      endcase
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_fault
      port_fault_flag u_flag
      (
        .clk(clk),
        .resetn(resetn),
        .softReset(softReset),
        .faultSet(portFaultSet[p]),
        .manualMode(manualMode),
        .disableCall(portDisableCall[p]),
        .retryExpired(retryExpired[p]),
        .flag(faultFlags[p])
      );
    end
  endgenerate

  // read data register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdData <= 8'h00;
    else
    begin
      case (code)
        pse_common_pkg::REG_COMMON_READ:
          rdData <= {faultFlags, CHIP_REV, CHIP_ID};
        pse_common_pkg::REG_COMMON_CTRL:
          rdData <= ctrl_reg;
        pse_common_pkg::REG_TEST_MODE:
          rdData <= test_reg;
        default:
          rdData <= 8'h00;
      endcase
    end
  end

  // per-port write strobe goes only to addressed port
  always_comb
  begin
    portWriteStrobe = 4'h0;
    portWriteCommon = 1'b0;
    if (dataStrobe && selectReady && !selStrobe)
    begin
      if (code == pse_common_pkg::REG_PORT_CTRL1 ||
          code == pse_common_pkg::REG_PORT_CTRL2)
        portWriteStrobe[portSel] = 1'b1;
      if (code == pse_common_pkg::REG_COMMON_CTRL ||
          code == pse_common_pkg::REG_TEST_MODE)
        portWriteCommon = 1'b1;
    end
  end

  assign thermalFaultDisable = ctrl_reg[`CTRL_THERM_DIS];
  assign acHighDrive = ctrl_reg[`CTRL_AC_HIGH];
  assign acLowDrive = ctrl_reg[`CTRL_AC_LOW];
  assign voltFaultDisable = ctrl_reg[`CTRL_VOLT_DIS];
  assign allPortsOff = ctrl_reg[`CTRL_ALL_OFF];
  assign forceThermalShutdown = test_reg[`TEST_FORCE_THERM];
  assign porForceRun = test_reg[`TEST_POR_FORCE];
  assign discoveryTimersOff = test_reg[`TEST_DISC_TMR_DIS];
  assign discoveryHalt = test_reg[`TEST_DISC_HALT];
  assign disconnectDelayZero = test_reg[`TEST_DISC_FAST];
  assign retryTimerOff = test_reg[`TEST_RETRY_DIS];

  sequence s_reset_start;
    !softReset && ctrl_reg[`CTRL_SW_RESET];
  endsequence
  // sixteen cycles of reset, split to keep each repetition small
  sequence s_reset_run;
    softReset [*8] ##1 softReset [*8];
  endsequence
  // a control write that the block accepts
  sequence s_ctrl_write;
    dataStrobe && !selStrobe && selectReady && !softReset &&
    code == pse_common_pkg::REG_COMMON_CTRL;
  endsequence

  a_swreset_seq: assert property (
    @(posedge clk) disable iff (!resetn)
    s_reset_start |=> s_reset_run ##1 !softReset)
    else $error("software reset length wrong");
  a_swreset_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(softReset) |-> !ctrl_reg[`CTRL_SW_RESET])
    else $error("software reset bit not cleared");
  a_swreset_all: assert property (
    @(posedge clk) disable iff (!resetn)
    softReset |=> sel_reg == `SEL_RESET && ctrl_reg == `CTRL_RESET &&
    test_reg == `TEST_RESET && !selectReady && faultFlags == 4'h0)
    else $error("software reset left state behind");
  a_sel_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !selStrobe && !softReset |=> $stable(sel_reg))
    else $error("selection changed without strobe");
  a_sel_unused: assert property (
    @(posedge clk) disable iff (!resetn)
    sel_reg[7] == 1'b0 && sel_reg[2] == 1'b0)
    else $error("unused select bits set");
  a_therm_lock: assert property (
    @(posedge clk) disable iff (!resetn)
    probeDone && !softReset |=> $stable(thermalFaultDisable))
    else $error("thermal disable changed after probe");
  a_ctrl_write: assert property (
    @(posedge clk) disable iff (!resetn)
    s_ctrl_write |=>
    {acHighDrive, acLowDrive, voltFaultDisable, allPortsOff} ==
    $past(wrData[`CTRL_AC_HIGH:`CTRL_ALL_OFF]) &&
    ($past(probeDone) ||
    thermalFaultDisable == $past(wrData[`CTRL_THERM_DIS])))
    else $error("control write not applied");
  a_read_common: assert property (
    @(posedge clk) disable iff (!resetn)
    code == pse_common_pkg::REG_COMMON_READ |=>
    rdData[7:4] == $past(faultFlags) &&
    rdData[3:2] == CHIP_REV &&
    rdData[1:0] == CHIP_ID)
    else $error("common read data wrong");
  a_read_ctrl: assert property (
    @(posedge clk) disable iff (!resetn)
    code == pse_common_pkg::REG_COMMON_CTRL |=>
    rdData[`CTRL_THERM_DIS:`CTRL_ALL_OFF] == $past({thermalFaultDisable,
    acHighDrive, acLowDrive, voltFaultDisable, allPortsOff}) &&
    rdData[7:6] == 2'b00)
    else $error("control read data wrong");
  a_read_other: assert property (
    @(posedge clk) disable iff (!resetn)
    code != pse_common_pkg::REG_COMMON_READ &&
    code != pse_common_pkg::REG_COMMON_CTRL &&
    code != pse_common_pkg::REG_TEST_MODE |=> rdData == 8'h00)
    else $error("other code read not zero");
  a_port_strobe: assert property (
    @(posedge clk) disable iff (!resetn)
    |portWriteStrobe |-> portWriteStrobe == (4'h1 << portSel))
    else $error("port write to wrong port");
  a_common_strobe: assert property (
    @(posedge clk) disable iff (!resetn)
    portWriteCommon |-> portWriteStrobe == 4'h0 &&
    (code == pse_common_pkg::REG_COMMON_CTRL ||
    code == pse_common_pkg::REG_TEST_MODE))
    else $error("common write mixed with port write");
  a_test_unused: assert property (
    @(posedge clk) disable iff (!resetn)
    test_reg[7] == 1'b0 && test_reg[0] == 1'b0 &&
    ctrl_reg[7:6] == 2'b00)
    else $error("unused register bits set");
  a_test_write: assert property (
    @(posedge clk) disable iff (!resetn)
    dataStrobe && !selStrobe && selectReady && !softReset &&
    code == pse_common_pkg::REG_TEST_MODE |=>
    forceThermalShutdown == $past(wrData[6]))
    else $error("test write not applied");
endmodule // pse_common_register_decode

//--- logic/sel_sync.sv
// two-stage synchroniser for one level
// assumes asynchronous source
`timescale 1ns/1ps
module sel_sync
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // sel_sync

//--- verif/host_model.sv
// serial host stand-in: hands select and data bytes over as strobes
// assumes the block samples strobes on the rising clk edge
`timescale 1ns/1ps
module host_model
(
  input wire logic clk,
  output logic selStrobe,
  output logic [7:0] selByte,
  output logic dataStrobe,
  output logic [7:0] wrData
);
  initial
  begin
    selStrobe = 1'b0;
    selByte = 8'h00;
    dataStrobe = 1'b0;
    wrData = 8'h00;
  end
  // bits 7 and 2 always sent as zero; bus shows junk when idle
  task automatic sendSel(input logic [3:0] c, input logic [1:0] p);
    @(negedge clk);
    selStrobe = 1'b1;
    selByte = {1'b0, c, 1'b0, p};
    @(negedge clk);
    selStrobe = 1'b0;
    selByte = ~selByte;
  endtask
  task automatic sendData(input logic [7:0] d);
    @(negedge clk);
    dataStrobe = 1'b1;
    wrData = d;
    @(negedge clk);
    dataStrobe = 1'b0;
    wrData = ~wrData;
  endtask
endmodule // host_model

//--- verif/pse_common_register_decode_test.sv
// self-checking bench for the common register decode block
// assumes host_model drives the select and data strobes
`timescale 1ns/1ps
module pse_common_register_decode_test;
  logic clk, resetn, selStrobe, dataStrobe, manualModePin, probeDone;
  logic [7:0] selByte, wrData, rdData;
  logic [3:0] portFaultSet, portDisableCall, retryExpired, regCode;
  logic [3:0] portWriteStrobe;
  logic [1:0] portSel;
  logic portWriteCommon, thermalFaultDisable, acHighDrive, acLowDrive;
  logic voltFaultDisable, allPortsOff, softResetActive;
  logic forceThermalShutdown, porForceRun, discoveryTimersOff;
  logic discoveryHalt, disconnectDelayZero, retryTimerOff;
  logic [7:0] ctl, tst;
  int n_mismatch = 0;
  int num_checks = 0;
  assign ctl = {2'h0, thermalFaultDisable, acHighDrive, acLowDrive,
    voltFaultDisable, allPortsOff, 1'b0};
  assign tst = {1'b0, forceThermalShutdown, porForceRun, discoveryTimersOff,
    discoveryHalt, disconnectDelayZero, retryTimerOff, 1'b0};
  host_model u_host (.clk(clk), .selStrobe(selStrobe), .selByte(selByte),
    .dataStrobe(dataStrobe), .wrData(wrData));
  // revision and identity values are arbitrary
  pse_common_register_decode #(.CHIP_REV(2'h3), .CHIP_ID(2'h1)) u_dut (
    .clk(clk), .resetn(resetn), .selStrobe(selStrobe), .selByte(selByte),
    .dataStrobe(dataStrobe), .wrData(wrData), .portFaultSet(portFaultSet),
    .portDisableCall(portDisableCall), .retryExpired(retryExpired),
    .manualModePin(manualModePin), .probeDone(probeDone), .rdData(rdData),
    .regCode(regCode), .portSel(portSel), .portWriteStrobe(portWriteStrobe),
    .portWriteCommon(portWriteCommon),
    .thermalFaultDisable(thermalFaultDisable), .acHighDrive(acHighDrive),
    .acLowDrive(acLowDrive), .voltFaultDisable(voltFaultDisable),
    .allPortsOff(allPortsOff), .softResetActive(softResetActive),
    .forceThermalShutdown(forceThermalShutdown), .porForceRun(porForceRun),
    .discoveryTimersOff(discoveryTimersOff), .discoveryHalt(discoveryHalt),
    .disconnectDelayZero(disconnectDelayZero),
    .retryTimerOff(retryTimerOff));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] c, input logic [7:0] d);
    u_host.sendSel(c, 2'h0);
    u_host.sendData(d);
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] c, input logic [7:0] exp);
    u_host.sendSel(c, 2'h0);
    @(negedge clk);
    chk(rdData, exp);
  endtask
  task automatic t_reset;
    chk(ctl, 8'h00);
    chk(tst, 8'h00);
    chk({regCode, 2'h0, portSel}, 8'h00);
    rd(4'h0, 8'h0D);
    $display("done reset");
  endtask
  // every code and port, with the write strobe fan-out seen mid-strobe
  task automatic t_decode;
    logic [3:0] c;
    for (int i = 0; i < 64; i++)
    begin
      c = 4'(i >> 2);
      u_host.sendSel(c, 2'(i));
      chk({regCode, 2'h0, portSel}, {c, 2'h0, 2'(i)});
      fork
        u_host.sendData(8'h00);
        begin
          @(negedge clk);
          #2;
          chk(8'(portWriteStrobe), (c == 4'h2 || c == 4'h3) ?
            8'h01 << (i % 4) : 8'h00);
          chk(8'(portWriteCommon), 8'(c == 4'h1 || c == 4'hF));
          chk(rdData, (c == 4'h0) ? 8'h0D : 8'h00);
        end
      join
    end
    $display("done decode");
  endtask
  task automatic t_ctrl;
    wr(4'h1, 8'hFE);
    chk(ctl, 8'h3E);
    rd(4'h1, 8'h3E);
    probeDone = 1'b1;
    wr(4'h1, 8'h00);
    chk(ctl, 8'h20);
    probeDone = 1'b0;
    wr(4'h1, 8'h00);
    chk(ctl, 8'h00);
    $display("done control");
  endtask
  task automatic t_test;
    wr(4'hF, 8'hFF);
    chk(tst, 8'h7E);
    rd(4'hF, 8'h7E);
    wr(4'hF, 8'h00);
    chk(tst, 8'h00);
    $display("done test register");
  endtask
  // sel picks the line pulsed for port p (0 fault set, 1 retry expiry, 2 disable call), then reads the flags
  task automatic pulse(input int sel, input int p, input logic [3:0] exp);
    @(negedge clk);
    if (sel == 0) portFaultSet = 4'h1 << p;
    if (sel == 1) retryExpired = 4'h1 << p;
    if (sel == 2) portDisableCall = 4'h1 << p;
    @(negedge clk);
    portFaultSet = 4'h0;
    retryExpired = 4'h0;
    portDisableCall = 4'h0;
    repeat (2) @(negedge clk);
    chk(8'(rdData[7:4]), 8'(exp));
  endtask
  task automatic t_fault;
    u_host.sendSel(4'h0, 2'h0);
    manualModePin = 1'b1;
    repeat (4) @(negedge clk);
    for (int p = 0; p < 4; p++)
    begin
      pulse(0, p, 4'h1 << p);
      pulse(1, p, 4'h1 << p);
      pulse(2, p, 4'h0);
    end
    manualModePin = 1'b0;
    repeat (4) @(negedge clk);
    for (int p = 0; p < 4; p++)
    begin
      pulse(0, p, 4'h1 << p);
      pulse(1, p, 4'h0);
    end
    $display("done fault flags");
  endtask
  task automatic t_soft;
    int n;
    pulse(0, 0, 4'h1);
    wr(4'hF, 8'h02);
    wr(4'h1, 8'h1F);
    n = 0;
    for (int i = 0; i < 4 && softResetActive !== 1'b1; i++)
      @(negedge clk);
    while (softResetActive === 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), 8'h10);
    chk(ctl, 8'h00);
    chk({regCode, 2'h0, portSel}, 8'h00);
    rd(4'h1, 8'h00);
    chk(tst, 8'h00);
    rd(4'h0, 8'h0D);
    $display("done soft reset");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    resetn = 1'b0;
    manualModePin = 1'b0;
    probeDone = 1'b0;
    portFaultSet = 4'h0;
    portDisableCall = 4'h0;
    retryExpired = 4'h0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_decode();
    t_ctrl();
    t_test();
    t_fault();
    t_soft();
    close_out();
  end
endmodule // pse_common_register_decode_test
